// [core/scftp_defines.vh]
// Shared offsets, reset values and field positions of the serial config block
`ifndef SCFTP_DEFINES_VH
`define SCFTP_DEFINES_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SCFTP_FRAME_BITS    5'h10
`define SCFTP_ADDR_READY    5'h08
`define SCFTP_DIR_BIT       15
`define SCFTP_ADDR_HI       13
`define SCFTP_ADDR_LO       8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCFTP_ADDR_CLK_CTRL 6'h01
`define SCFTP_ADDR_PAT_CTRL 6'h02
`define SCFTP_ADDR_SEQ_BASE 6'h08
`define SCFTP_ADDR_SEQ_LAST 6'h0b
`define SCFTP_ADDR_USR_BASE 6'h0c
`define SCFTP_ADDR_USR_LAST 6'h0f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCFTP_RST_CLK_CTRL  8'h10
`define SCFTP_RST_PAT_CTRL  8'h00
`define SCFTP_RST_SEQ       8'h48
`define SCFTP_RST_USR       8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCFTP_CLK_INVERT    7
`define SCFTP_CLK_DIV2      6
`define SCFTP_PAT_ENABLE    0
`define SCFTP_SEQ_LO_POS    2
`define SCFTP_SEQ_HI_POS    5

`endif

// [core/scftp_serial_port.v]
// Three-wire serial frame port: shifts frames and issues register writes
`timescale 1ns/1ps
`include "scftp_defines.vh"

module scftp_serial_port (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        sclk,
  input  wire        select_n,
  input  wire        serial_in,
  input  wire [7:0]  rd_data,
  output wire [5:0]  rd_addr,
  output reg         serial_out,
  output wire        serial_out_oe,
  output reg         wr_en,
  output reg  [5:0]  wr_addr,
  output reg  [7:0]  wr_data,
  output reg  [5:0]  last_addr
);

  reg        sclk_q;
  reg        select_n_q;
  reg        active_q;
  reg [4:0]  count_q;
  reg [15:0] shift_q;
  reg [7:0]  rd_buf_q;
  reg        drive_q;

  wire sclk_rise = sclk & ~sclk_q;
  wire sclk_fall = ~sclk & sclk_q;
  wire sel_fall  = ~select_n & select_n_q;
  wire sel_rise  = select_n & ~select_n_q;
  wire is_read   = shift_q[`SCFTP_DIR_BIT - 8];

  assign rd_addr       = shift_q[5:0];
  assign serial_out_oe = drive_q & ~select_n;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q     <= 1'b0;
      select_n_q <= 1'b1;
      active_q   <= 1'b0;
      count_q    <= 5'h00;
      shift_q    <= 16'h0000;
      rd_buf_q   <= 8'h00;
      drive_q    <= 1'b0;
      serial_out <= 1'b0;
      wr_en      <= 1'b0;
      wr_addr    <= 6'h00;
      wr_data    <= 8'h00;
      last_addr  <= 6'h00;
    end else begin
      sclk_q     <= sclk;
      select_n_q <= select_n;
      wr_en      <= 1'b0;
      if (sel_fall) begin
        active_q <= 1'b1;
        count_q  <= 5'h00;
        drive_q  <= 1'b0;
      end else if (sel_rise) begin
        active_q <= 1'b0;
        drive_q  <= 1'b0;
        if (active_q && count_q == `SCFTP_FRAME_BITS) begin
          last_addr <= shift_q[`SCFTP_ADDR_HI:`SCFTP_ADDR_LO];
          if (!shift_q[`SCFTP_DIR_BIT]) begin
            wr_en   <= 1'b1;
            wr_addr <= shift_q[`SCFTP_ADDR_HI:`SCFTP_ADDR_LO];
            wr_data <= shift_q[7:0];
          end
        end
      end else if (active_q && !select_n) begin
        if (sclk_rise && count_q != `SCFTP_FRAME_BITS) begin
          shift_q <= {shift_q[14:0], serial_in};
          count_q <= count_q + 5'h01;
        end
        if (sclk_fall && count_q >= `SCFTP_ADDR_READY &&
            count_q != `SCFTP_FRAME_BITS) begin
          if (count_q == `SCFTP_ADDR_READY) begin
            drive_q    <= is_read;
            rd_buf_q   <= {rd_data[6:0], 1'b0};
            serial_out <= rd_data[7];
          end else begin
            rd_buf_q   <= {rd_buf_q[6:0], 1'b0};
            serial_out <= rd_buf_q[7];
          end
        end
      end
    end
  end

endmodule

// [core/scftp_pattern_gen.v]
// Eight-entry test pattern sequencer with sample word capture
`timescale 1ns/1ps
`include "scftp_defines.vh"

module scftp_pattern_gen (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        advance,
  input  wire        enable,
  input  wire [23:0] seq_codes,
  input  wire [15:0] user_word0,
  input  wire [15:0] user_word1,
  input  wire [15:0] sample_data,
  output reg  [15:0] word_q
);

  reg  [2:0] index_q;
  wire [2:0] code = seq_codes[index_q * 3 +: 3];

  // ----------------------------------------------------------------
  // Pattern lookup
  // ----------------------------------------------------------------
  function [15:0] pattern_word;
    input [2:0]  c;
    input [15:0] u0;
    input [15:0] u1;
    begin
      case (c)
        3'h0:    pattern_word = 16'h0000;
        3'h1:    pattern_word = 16'hffff;
        3'h2:    pattern_word = 16'haaaa;
        3'h3:    pattern_word = 16'h8000;
        3'h4:    pattern_word = 16'hff00;
        3'h5:    pattern_word = 16'h00ff;
        3'h6:    pattern_word = u0;
        default: pattern_word = u1;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      index_q <= 3'h0;
      word_q  <= 16'h0000;
    end else if (advance) begin
      if (enable) begin
        word_q  <= pattern_word(code, user_word0, user_word1);
        index_q <= index_q + 3'h1;
      end else begin
        word_q  <= sample_data;
        index_q <= 3'h0;
      end
    end
  end

endmodule

// [core/scftp_top.v]
// Serial configuration port, register file, clock control and pattern output
`timescale 1ns/1ps
`include "scftp_defines.vh"

module scftp_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        sclk,
  input  wire        select_n,
  input  wire        serial_in,
  output wire        serial_out,
  output wire        serial_out_oe,
  input  wire        input_clock,
  input  wire [15:0] sample_data,
  output reg         output_clock,
  output reg  [7:0]  data_out,
  output reg         sample_strobe,
  output wire [5:0]  last_addr
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg  [7:0]  clk_ctrl_q;
  reg  [7:0]  pat_ctrl_q;
  reg  [7:0]  seq_q [0:3];
  reg  [7:0]  usr_q [0:3];
  reg  [7:0]  rd_data;
  wire [5:0]  rd_addr;
  wire        wr_en;
  wire [5:0]  wr_addr;
  wire [7:0]  wr_data;
  wire [23:0] seq_codes;
  wire [15:0] word;

  function in_range;
    input [5:0] a;
    input [5:0] lo;
    input [5:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_ctrl_q <= `SCFTP_RST_CLK_CTRL;
      pat_ctrl_q <= `SCFTP_RST_PAT_CTRL;
      seq_q[0]   <= `SCFTP_RST_SEQ;
      seq_q[1]   <= `SCFTP_RST_SEQ;
      seq_q[2]   <= `SCFTP_RST_SEQ;
      seq_q[3]   <= `SCFTP_RST_SEQ;
      usr_q[0]   <= `SCFTP_RST_USR;
      usr_q[1]   <= `SCFTP_RST_USR;
      usr_q[2]   <= `SCFTP_RST_USR;
      usr_q[3]   <= `SCFTP_RST_USR;
    end else if (wr_en) begin
      if (wr_addr == `SCFTP_ADDR_CLK_CTRL)
        clk_ctrl_q <= wr_data;
      if (wr_addr == `SCFTP_ADDR_PAT_CTRL)
        pat_ctrl_q <= wr_data;
      if (in_range(wr_addr, `SCFTP_ADDR_SEQ_BASE, `SCFTP_ADDR_SEQ_LAST))
        seq_q[wr_addr[1:0]] <= wr_data;
      if (in_range(wr_addr, `SCFTP_ADDR_USR_BASE, `SCFTP_ADDR_USR_LAST))
        usr_q[wr_addr[1:0]] <= wr_data;
    end
  end

  // Read mux, undefined addresses read zero
  always @* begin
    rd_data = 8'h00;
    if (rd_addr == `SCFTP_ADDR_CLK_CTRL)
      rd_data = clk_ctrl_q;
    else if (rd_addr == `SCFTP_ADDR_PAT_CTRL)
      rd_data = pat_ctrl_q;
    else if (in_range(rd_addr, `SCFTP_ADDR_SEQ_BASE, `SCFTP_ADDR_SEQ_LAST))
      rd_data = seq_q[rd_addr[1:0]];
    else if (in_range(rd_addr, `SCFTP_ADDR_USR_BASE, `SCFTP_ADDR_USR_LAST))
      rd_data = usr_q[rd_addr[1:0]];
  end

  // Two entries per sequence register, lower entry in bits 4:2
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_seq
      assign seq_codes[g*6 +: 3] =
        seq_q[g][`SCFTP_SEQ_LO_POS +: 3];
      assign seq_codes[g*6+3 +: 3] =
        seq_q[g][`SCFTP_SEQ_HI_POS +: 3];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  scftp_serial_port scftp_serial_port_inst (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .sclk          (sclk),
    .select_n      (select_n),
    .serial_in     (serial_in),
    .rd_data       (rd_data),
    .rd_addr       (rd_addr),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .last_addr     (last_addr)
  );

  // ----------------------------------------------------------------
  // Clock control
  // ----------------------------------------------------------------
  reg  in_clk_q;
  reg  div_q;
  reg  int_clk_q;
  reg  fall_d_q;
  reg  rise_d_q;
  wire in_rise  = input_clock & ~in_clk_q;
  wire base_clk = clk_ctrl_q[`SCFTP_CLK_DIV2] ? div_q
                                              : input_clock;
  wire int_clk  = base_clk ^ clk_ctrl_q[`SCFTP_CLK_INVERT];
  wire int_fall = int_clk_q & ~int_clk;
  wire int_rise = ~int_clk_q & int_clk;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_clk_q      <= 1'b0;
      div_q         <= 1'b0;
      int_clk_q     <= 1'b0;
      fall_d_q      <= 1'b0;
      rise_d_q      <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      in_clk_q      <= input_clock;
      if (in_rise)
        div_q <= ~div_q;
      int_clk_q     <= int_clk;
      fall_d_q      <= int_fall;
      rise_d_q      <= int_rise;
      sample_strobe <= int_fall;
    end
  end

  // ----------------------------------------------------------------
  // Pattern sequencer
  // ----------------------------------------------------------------
  scftp_pattern_gen scftp_pattern_gen_inst (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .advance     (int_fall),
    .enable      (pat_ctrl_q[`SCFTP_PAT_ENABLE]),
    .seq_codes   (seq_codes),
    .user_word0  ({usr_q[1], usr_q[0]}),
    .user_word1  ({usr_q[3], usr_q[2]}),
    .sample_data (sample_data),
    .word_q      (word)
  );

  // ----------------------------------------------------------------
  // Double data rate output
  // ----------------------------------------------------------------
  function [7:0] pick_bits;
    input [15:0] w;
    input        odd;
    integer      i;
    begin
      pick_bits = 8'h00;
      for (i = 0; i < 8; i = i + 1)
        pick_bits[i] = odd ? w[2*i+1] : w[2*i];
    end
  endfunction

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_clock <= 1'b0;
      data_out     <= 8'h00;
    end else begin
      if (fall_d_q) begin
        output_clock <= 1'b0;
        data_out     <= pick_bits(word, 1'b1);
      end else if (rise_d_q) begin
        output_clock <= 1'b1;
        data_out     <= pick_bits(word, 1'b0);
      end
    end
  end

endmodule

// [core/_unused_guard.v]
// Holds no logic; every module of the block lives in its own file

// [test/scftp_props.sv]
// Port checker for the serial config and pattern block
`timescale 1ns/1ps
module scftp_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       sclk,
  input wire logic       select_n,
  input wire logic       serial_out,
  input wire logic       serial_out_oe,
  input wire logic       output_clock,
  input wire logic [7:0] data_out,
  input wire logic       sample_strobe,
  input wire logic [5:0] last_addr
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence frame_open;
    $fell(select_n);
  endsequence
  sequence frame_close;
    $rose(select_n);
  endsequence
  a_oe_in_frame: assert property (
    $rose(serial_out_oe) |-> !select_n) else $error("oe outside frame");
  a_out_on_fall: assert property (
    $changed(serial_out) |-> !sclk) else $error("data moved, clock high");
  a_addr_on_release: assert property (
    $changed(last_addr) |-> $past(select_n) && !$past(select_n, 2))
    else $error("address latched away from select release");
  a_strobe_pulse: assert property (
    sample_strobe |=> !sample_strobe) else $error("strobe too long");
  a_data_with_clock: assert property (
    $changed(data_out) |-> $changed(output_clock))
    else $error("data moved without clock edge");
  a_clock_min_phase: assert property (
    $changed(output_clock) |=> $stable(output_clock) [*2])
    else $error("output clock phase too short");
  a_oe_late_start: assert property (
    frame_open |=> !serial_out_oe [*8]) else $error("oe too early");
  a_oe_drops_after: assert property (
    frame_close |-> ##[1:3] !serial_out_oe) else $error("oe stuck on");
endmodule

bind scftp_top scftp_props scftp_props_inst (
  .clk           (clk),
  .sys_rst       (sys_rst),
  .sclk          (sclk),
  .select_n      (select_n),
  .serial_out    (serial_out),
  .serial_out_oe (serial_out_oe),
  .output_clock  (output_clock),
  .data_out      (data_out),
  .sample_strobe (sample_strobe),
  .last_addr     (last_addr)
);

// [test/scftp_host_model.sv]
// Host model driving three-wire serial frames
`timescale 1ns/1ps
module scftp_host_model (
  input  wire clk,
  output reg  sclk,
  output reg  select_n,
  output reg  serial_in,
  input  wire serial_out,
  input  wire serial_out_oe
);
  // ----
  // Frame access
  // ----
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic xfer(input rd, input [5:0] a, input [7:0] d,
                      input integer n, output [7:0] q);
    reg [15:0] f;
    integer i;
    begin
      f = {rd, 1'b0, a, d};
      q = 8'h00;
      @(negedge clk) select_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < n; i = i + 1) begin
        serial_in = f[15 - i];
        repeat (4) @(negedge clk);
        // Undriven wire reads as the inverse of the last bit
        if (i > 7)
          q = {q[6:0], serial_out_oe ? serial_out : ~serial_out};
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      select_n = 1'b1;
      serial_in = ~serial_in;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// [test/scftp_test.sv]
// Self-checking bench for the serial config and pattern block
`timescale 1ns/1ps
module scftp_test;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         input_clock = 1'b0;
  reg  [15:0] sample_data = 16'hc35a;
  wire        sclk, select_n, serial_in, serial_out, serial_out_oe;
  wire        output_clock, sample_strobe;
  wire [7:0]  data_out;
  wire [5:0]  last_addr;
  integer     fails = 0;
  integer     compares = 0;
  integer     i, p;
  reg  [7:0]  q;
  reg  [15:0] w;
  time        t0;
  reg  [7:0]  cfg [0:7];
  reg  [15:0] seq [0:7];
  // ----
  // Design and host
  // ----
  scftp_top scftp_top_inst (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .input_clock(input_clock),
    .sample_data(sample_data), .output_clock(output_clock),
    .data_out(data_out), .sample_strobe(sample_strobe),
    .last_addr(last_addr));
  scftp_host_model scftp_host_model_inst (.clk(clk), .sclk(sclk),
    .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));
  always #20 clk = ~clk;
  always begin
    repeat (8) @(negedge clk);
    input_clock = ~input_clock;
  end
  // ----
  // Tasks
  // ----
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t: word %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    scftp_host_model_inst.xfer(1'b0, a, d, 16, q);
  endtask
  task rd_chk(input [5:0] a, input [7:0] exp);
    begin
      scftp_host_model_inst.xfer(1'b1, a, 8'hff, 16, q);
      chk8(q, exp);
    end
  endtask
  task get_word(output [15:0] v);
    reg [7:0] o, e;
    integer k;
    begin
      @(negedge output_clock);
      @(negedge clk) o = data_out;
      @(posedge output_clock);
      @(negedge clk) e = data_out;
      for (k = 0; k < 8; k = k + 1) begin
        v[2*k+1] = o[k];
        v[2*k] = e[k];
      end
    end
  endtask
  task period(output integer n);
    time t;
    begin
      @(posedge output_clock);
      t = $time;
      @(posedge output_clock);
      n = ($time - t) / 40;
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #(40 * 40000);
    fails = fails + 1;
    $display("ERROR %0t: timeout", $time);
    wrap_up;
  end
  // ----
  // Tests
  // ----
  initial begin
    {cfg[0], cfg[1], cfg[2], cfg[3]} = 32'h2068b0f8;
    {cfg[4], cfg[5], cfg[6], cfg[7]} = 32'h34127856;
    {seq[0], seq[1], seq[2], seq[3]} = 64'hff0000ff12345678;
    {seq[4], seq[5], seq[6], seq[7]} = 64'h0000ffffaaaa8000;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    rd_chk(6'h01, 8'h10);
    rd_chk(6'h02, 8'h00);
    for (i = 8; i < 16; i = i + 1)
      rd_chk(i[5:0], i < 12 ? 8'h48 : 8'h00);
    chk8({2'b00, last_addr}, 8'h0f);
    rd_chk(6'h0c, 8'h00);
    chk8({2'b00, last_addr}, 8'h0c);
    scftp_host_model_inst.xfer(1'b0, 6'h02, 8'h01, 10, q);
    chk8({2'b00, last_addr}, 8'h0c);
    rd_chk(6'h02, 8'h00);
    scftp_host_model_inst.xfer(1'b1, 6'h08, 8'h00, 16, q);
    rd_chk(6'h08, 8'h48);
    get_word(w);
    chk16(w, 16'hc35a);
    @(posedge sample_strobe);
    @(negedge clk) chk8({7'h00, input_clock}, 8'h00);
    period(p);
    chk16(p[15:0], 16'd16);
    wr(6'h02, 8'h01);
    get_word(w);
    get_word(w);
    chk16(w, 16'haaaa);
    wr(6'h01, 8'h50);
    rd_chk(6'h01, 8'h50);
    period(p);
    chk16(p[15:0], 16'd32);
    t0 = $time;
    wr(6'h01, 8'hd0);
    period(p);
    chk16(p[15:0], 16'd32);
    p = (($time - t0) / 40) % 32;
    chk16(p[15:0], 16'd16);
    wr(6'h01, 8'h10);
    for (i = 0; i < 8; i = i + 1)
      wr(6'h08 + i[5:0], cfg[i]);
    i = 0;
    w = 16'h0000;
    while (w !== 16'h8000 && i < 20) begin
      get_word(w);
      i = i + 1;
    end
    for (i = 0; i < 8; i = i + 1) begin
      get_word(w);
      chk16(w, seq[i]);
    end
    wr(6'h02, 8'h00);
    get_word(w);
    get_word(w);
    chk16(w, 16'hc35a);
    wrap_up;
  end
endmodule
